// File: include/uda_pkg.sv
// constants and types for the device-mode address filter and interrupt flags
// assumes one 100 MHz clock domain shared with both device engines
`default_nettype none

package uda_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] OFS_IEN1 = 16'hC08C;
  localparam logic [15:0] OFS_ADDR1 = 16'hC08E;
  localparam logic [15:0] OFS_STAT1 = 16'hC090;
  localparam logic [15:0] OFS_IEN2 = 16'hC0AC;
  localparam logic [15:0] OFS_ADDR2 = 16'hC0AE;
  localparam logic [15:0] OFS_STAT2 = 16'hC0B0;

  // ==========================================================
  // implemented bits per engine
  localparam logic [15:0] IEN_MASK1 = 16'hCBFF;
  localparam logic [15:0] IEN_MASK2 = 16'h0BFF;
  localparam logic [15:0] STAT_MASK1 = 16'hC3FF;
  localparam logic [15:0] STAT_MASK2 = 16'h03FF;

  // ==========================================================
  // field positions
  localparam int BIT_VBUS = 15;
  localparam int BIT_ID = 14;
  localparam int BIT_SOF_TMO = 11;
  localparam int BIT_SOF = 9;
  localparam int BIT_BUSRST = 8;
  localparam int ADDR_W = 7;

  // ==========================================================
  // reset values and counts
  localparam logic [15:0] IEN_RESET = 16'h0000;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [15:0] RDATA_RESET = 16'h0000;
  localparam logic [1:0] SYNC_FILL = 2'h3;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    UDA_K_NONE = 2'h0,
    UDA_K_IEN = 2'h1,
    UDA_K_ADDR = 2'h2,
    UDA_K_STAT = 2'h3
  } uda_kind_e;

  typedef enum logic [2:0] {
    UDA_X_ACK_TX = 3'h0,
    UDA_X_ACK_RX = 3'h1,
    UDA_X_STALL_TX = 3'h2,
    UDA_X_TIMEOUT = 3'h3,
    UDA_X_IN_ERR = 3'h4,
    UDA_X_OUT_ERR = 3'h5,
    UDA_X_NAK_TX = 3'h6,
    UDA_X_NONE = 3'h7
  } uda_xact_e;

endpackage

`default_nettype wire

// File: rtl/uda_irq_ctrl.sv
// address filter, interrupt enables and sticky flags for two device engines
// assumes engine events arrive as one-cycle pulses on clk; vbus/id come from pins
`default_nettype none

module uda_irq_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [15:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  output logic [15:0] cpu_rdata,
  input wire logic php_wr,
  input wire logic php_rd,
  input wire logic [15:0] php_addr,
  input wire logic [15:0] php_wdata,
  output logic [15:0] php_rdata,
  input wire logic [1:0] token_valid,
  input wire logic [1:0][6:0] token_addr,
  output logic [1:0] addr_match,
  input wire logic [1:0] xact_done,
  input wire logic [1:0][2:0] xact_ep,
  input wire uda_pkg::uda_xact_e [1:0] xact_code,
  input wire logic [1:0][7:0] nak_irq_en,
  input wire logic [1:0] usb_reset_det,
  input wire logic [1:0] sof_eop_rx,
  input wire logic vbus_above_pin,
  input wire logic otg_id_pin,
  output logic [1:0] irq
);
  import uda_pkg::*;

  // ==========================================================
  // helpers
  function automatic uda_kind_e reg_kind(input logic [15:0] a, input logic e);
    uda_kind_e k;
    k = UDA_K_NONE;
    if (a == (e ? OFS_IEN2 : OFS_IEN1)) begin
      k = UDA_K_IEN;
    end else if (a == (e ? OFS_ADDR2 : OFS_ADDR1)) begin
      k = UDA_K_ADDR;
    end else if (a == (e ? OFS_STAT2 : OFS_STAT1)) begin
      k = UDA_K_STAT;
    end
    return k;
  endfunction

  function automatic logic [15:0] ien_mask(input logic e);
    return e ? IEN_MASK2 : IEN_MASK1;
  endfunction

  function automatic logic [15:0] stat_mask(input logic e);
    return e ? STAT_MASK2 : STAT_MASK1;
  endfunction

  function automatic logic xact_counts(input uda_xact_e c, input logic nak_en);
    logic r;
    r = 1'b0;
    case (c)
      UDA_X_ACK_TX, UDA_X_ACK_RX, UDA_X_STALL_TX,
      UDA_X_TIMEOUT, UDA_X_IN_ERR, UDA_X_OUT_ERR: r = 1'b1;
      UDA_X_NAK_TX: r = nak_en;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // address register is write-only, so it reads back as zero
  function automatic logic [15:0] read_word(input logic [15:0] a,
                                            input logic [1:0][15:0] ien,
                                            input logic [1:0][15:0] stat);
    logic [15:0] d;
    d = 16'h0000;
    for (int e = 0; e < 2; e++) begin
      case (reg_kind(a, e[0]))
        UDA_K_IEN: d = ien[e];
        UDA_K_STAT: d = stat[e];
        default: d = d;
      endcase
    end
    return d;
  endfunction

  // ==========================================================
  // state
  logic [1:0][15:0] ien_r;
  logic [1:0][15:0] ien_nxt;
  logic [1:0][15:0] flags_r;
  logic [1:0][15:0] flags_nxt;
  logic [1:0][6:0] addr_r;
  logic [1:0][6:0] addr_nxt;
  logic [1:0][15:0] set_vec;
  logic [1:0][15:0] clr_vec;
  logic [1:0] tok_match_r;
  logic [1:0] irq_r;
  logic [15:0] cpu_rdata_r;
  logic [15:0] php_rdata_r;
  logic vbus_s1_r;
  logic vbus_s2_r;
  logic vbus_d_r;
  logic id_s1_r;
  logic id_s2_r;
  logic id_d_r;
  logic [1:0] fill_r;
  logic vbus_edge;
  logic id_edge;

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      vbus_s1_r <= 1'b0;
      vbus_s2_r <= 1'b0;
      vbus_d_r <= 1'b0;
      id_s1_r <= 1'b0;
      id_s2_r <= 1'b0;
      id_d_r <= 1'b0;
    end else begin
      vbus_s1_r <= vbus_above_pin;
      vbus_s2_r <= vbus_s1_r;
      vbus_d_r <= vbus_s2_r;
      id_s1_r <= otg_id_pin;
      id_s2_r <= id_s1_r;
      id_d_r <= id_s2_r;
    end
  end

  // edges are ignored until the chain has refilled, else reset release fakes one
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_r <= 2'h0;
    end else if (fill_r != SYNC_FILL) begin
      fill_r <= fill_r + 2'h1;
    end
  end

  assign vbus_edge = (fill_r == SYNC_FILL) && (vbus_s2_r ^ vbus_d_r);
  assign id_edge = (fill_r == SYNC_FILL) && (id_s2_r ^ id_d_r);

  // ==========================================================
  // address filter
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      addr_match[e] = token_valid[e] && (token_addr[e] == addr_r[e]);
    end
  end

  // the last token decides whether the following handshake belongs to us
  always_ff @(posedge clk) begin
    if (reset) begin
      tok_match_r <= 2'h0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        if (token_valid[e]) begin
          tok_match_r[e] <= addr_match[e];
        end
      end
    end
  end

  // ==========================================================
  // next values for registers
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      set_vec[e] = 16'h0000;
      if (xact_done[e] && tok_match_r[e] &&
          xact_counts(xact_code[e], nak_irq_en[e][xact_ep[e]])) begin
        set_vec[e][xact_ep[e]] = 1'b1;
      end
      set_vec[e][BIT_BUSRST] = usb_reset_det[e];
      set_vec[e][BIT_SOF] = sof_eop_rx[e];
      if (e == 0) begin
        set_vec[e][BIT_VBUS] = vbus_edge;
        set_vec[e][BIT_ID] = id_edge;
      end
      clr_vec[e] = 16'h0000;
      if (cpu_wr && reg_kind(cpu_addr, e[0]) == UDA_K_STAT) begin
        clr_vec[e] = clr_vec[e] | cpu_wdata;
      end
      if (php_wr && reg_kind(php_addr, e[0]) == UDA_K_STAT) begin
        clr_vec[e] = clr_vec[e] | php_wdata;
      end
      // set is applied after clear so a same-cycle event survives
      flags_nxt[e] = ((flags_r[e] & ~clr_vec[e]) | set_vec[e]) & stat_mask(e[0]);
      ien_nxt[e] = ien_r[e];
      addr_nxt[e] = addr_r[e];
      if (cpu_wr && reg_kind(cpu_addr, e[0]) == UDA_K_IEN) begin
        ien_nxt[e] = cpu_wdata & ien_mask(e[0]);
      end
      if (php_wr && reg_kind(php_addr, e[0]) == UDA_K_IEN) begin
        ien_nxt[e] = php_wdata & ien_mask(e[0]);
      end
      if (cpu_wr && reg_kind(cpu_addr, e[0]) == UDA_K_ADDR) begin
        addr_nxt[e] = cpu_wdata[ADDR_W-1:0];
      end
      if (php_wr && reg_kind(php_addr, e[0]) == UDA_K_ADDR) begin
        addr_nxt[e] = php_wdata[ADDR_W-1:0];
      end
    end
  end

  // ==========================================================
  // register file, one instance per engine
  always_ff @(posedge clk) begin
    if (reset) begin
      flags_r <= {STAT_RESET, STAT_RESET};
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ien_r <= {IEN_RESET, IEN_RESET};
    end else begin
      ien_r <= ien_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      addr_r <= {ADDR_RESET, ADDR_RESET};
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // registered so irq changes in the same cycle as the flags it reflects
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_r <= 2'h0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        irq_r[e] <= |(flags_nxt[e] & ien_nxt[e]);
      end
    end
  end

  assign irq = irq_r;

  // ==========================================================
  // read ports, one cycle latency, last value held
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_rdata_r <= RDATA_RESET;
    end else if (cpu_rd) begin
      cpu_rdata_r <= read_word(cpu_addr, ien_r, flags_r);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      php_rdata_r <= RDATA_RESET;
    end else if (php_rd) begin
      php_rdata_r <= read_word(php_addr, ien_r, flags_r);
    end
  end

  assign cpu_rdata = cpu_rdata_r;
  assign php_rdata = php_rdata_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_ep_event_set: assert property (
    xact_done[0] && tok_match_r[0] &&
    xact_code[0] != UDA_X_NAK_TX && xact_code[0] != UDA_X_NONE
    |=> flags_r[0][$past(xact_ep[0])])
    else $error("endpoint event did not set its flag");

  a_nak_gated: assert property (
    xact_done[1] && tok_match_r[1] && xact_code[1] == UDA_X_NAK_TX &&
    !nak_irq_en[1][xact_ep[1]] && !flags_r[1][xact_ep[1]]
    |=> !flags_r[1][$past(xact_ep[1])])
    else $error("nak set a flag while its enable was off");

  a_foreign_ignored: assert property (
    token_valid[1] && token_addr[1] != addr_r[1] ##1 xact_done[1] && !token_valid[1]
    && !flags_r[1][xact_ep[1]]
    |=> !flags_r[1][$past(xact_ep[1])])
    else $error("transaction to another address raised a flag");

  a_addr_reset: assert property (
    $fell(reset) |-> addr_r == {ADDR_RESET, ADDR_RESET})
    else $error("device address not zero after reset");

  a_w1c_clear: assert property (
    cpu_wr && cpu_addr == OFS_STAT1 && cpu_wdata[BIT_BUSRST] && !usb_reset_det[0]
    |=> !flags_r[0][BIT_BUSRST])
    else $error("write of one did not clear the flag");

  a_set_wins: assert property (
    php_wr && php_addr == OFS_STAT2 && php_wdata[BIT_SOF] && sof_eop_rx[1]
    |=> flags_r[1][BIT_SOF])
    else $error("clear beat a same-cycle event");

  a_w0_keeps: assert property (
    cpu_wr && cpu_addr == OFS_STAT2 && cpu_wdata == 16'h0000 && !php_wr
    |=> flags_r[1] == $past(flags_r[1]) || $past(|set_vec[1]))
    else $error("writing zero disturbed the flags");

  a_php_read: assert property (
    php_rd && php_addr == OFS_STAT1 |=> php_rdata == $past(flags_r[0]))
    else $error("host port read of status wrong");

  a_vbus_edge: assert property (
    $changed(vbus_s2_r) && fill_r == SYNC_FILL ##1 1'b1 |-> flags_r[0][BIT_VBUS])
    else $error("vbus crossing did not set its flag");

  a_id_edge: assert property (
    $changed(id_s2_r) && fill_r == SYNC_FILL |=> flags_r[0][BIT_ID])
    else $error("id edge did not set its flag");

  a_eng2_reserved: assert property (
    flags_r[1][15:10] == 6'h00 && ien_r[1][15:14] == 2'h0)
    else $error("engine two reserved bits set");

  a_sof_flag: assert property (
    sof_eop_rx[0] |=> flags_r[0][BIT_SOF])
    else $error("sof/eop did not set bit nine");

  a_bus_reset: assert property (
    usb_reset_det[0] |=> flags_r[0][BIT_BUSRST])
    else $error("bus reset did not set bit eight");

  a_irq_follow: assert property (
    irq[0] == |(flags_r[0] & ien_r[0]) && irq[1] == |(flags_r[1] & ien_r[1]))
    else $error("irq does not match enabled flags");

  a_enable_gates: assert property (
    cpu_wr && cpu_addr == OFS_IEN1 && cpu_wdata == 16'h0000 && !php_wr
    |=> !irq[0] && ien_r[0] == 16'h0000)
    else $error("cleared enables left irq active");

  c_ep_irq: cover property (xact_done[0] && tok_match_r[0] ##1 irq[0]);
  c_set_clear_same: cover property (php_wr && php_addr == OFS_STAT2 && |set_vec[1]);
  c_vbus_flag: cover property ($rose(flags_r[0][BIT_VBUS]));
  c_addr_change: cover property (cpu_wr && cpu_addr == OFS_ADDR2 ##1 addr_match[1]);

endmodule

`default_nettype wire

// File: tb/uda_usb_host_model.sv
// host-side model: sends a token to one engine, then that transaction's result
// assumes the bench raises go for one cycle, just after a rising edge
`default_nettype none

module uda_usb_host_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic eng,
  input wire logic [6:0] dev_addr,
  input wire logic [2:0] ep,
  input wire uda_pkg::uda_xact_e code,
  input wire logic [1:0] gap,
  output logic [1:0] token_valid,
  output logic [1:0][6:0] token_addr,
  output logic [1:0] xact_done,
  output logic [1:0][2:0] xact_ep,
  output uda_pkg::uda_xact_e [1:0] xact_code
);
  timeunit 1ns;
  timeprecision 1ps;
  import uda_pkg::*;

  logic [2:0] wait_r;
  logic eng_r;
  logic [2:0] ep_r;
  uda_xact_e code_r;

  initial begin
    token_valid = 2'h0;
    token_addr = '0;
    xact_done = 2'h0;
    xact_ep = '0;
    xact_code[0] = UDA_X_NONE;
    xact_code[1] = UDA_X_NONE;
    wait_r = 3'h0;
  end

  // ==========================================================
  // token first, result after a chosen gap (prompt or slow host)
  always @(posedge clk) begin
    token_valid <= 2'h0;
    xact_done <= 2'h0;
    // token_addr and xact_ep wander while idle and xact_code idles at UDA_X_NONE, so a stale value never passes
    token_addr <= ~token_addr;
    xact_ep <= ~xact_ep;
    xact_code[0] <= UDA_X_NONE;
    xact_code[1] <= UDA_X_NONE;
    if (reset) begin
      wait_r <= 3'h0;
    end else if (go) begin
      token_valid[eng] <= 1'b1;
      token_addr[eng] <= dev_addr;
      wait_r <= {1'b0, gap} + 3'h1;
      eng_r <= eng;
      ep_r <= ep;
      code_r <= code;
    end else if (wait_r == 3'h1) begin
      xact_done[eng_r] <= 1'b1;
      xact_ep[eng_r] <= ep_r;
      xact_code[eng_r] <= code_r;
      wait_r <= 3'h0;
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end
  end
endmodule

`default_nettype wire

// File: tb/tb_usb_device_addr_irq_status.sv
// self-checking bench for the address filter and interrupt flags
// assumes uda_pkg and the host model are compiled first
`default_nettype none

module tb_usb_device_addr_irq_status;
  timeunit 1ns;
  timeprecision 1ps;
  import uda_pkg::*;

  // ==========================================================
  // signals (index 0 is the embedded cpu, 1 the parallel host port)
  logic clk, reset, vbus, id_pin, go, h_eng;
  logic [1:0] wr, rd, token_valid, addr_match, xact_done, irq, rst_det, sof_rx, h_gap;
  logic [1:0][15:0] addr, wdata;
  logic [15:0] cpu_rdata, php_rdata;
  logic [1:0][6:0] token_addr;
  logic [1:0][2:0] xact_ep;
  logic [1:0][7:0] nak_en;
  logic [6:0] h_addr;
  logic [2:0] h_ep;
  uda_xact_e h_code;
  uda_xact_e [1:0] xact_code;
  int miscompares, compares;

  uda_irq_ctrl dut (.clk(clk), .reset(reset), .cpu_wr(wr[0]), .cpu_rd(rd[0]),
    .cpu_addr(addr[0]), .cpu_wdata(wdata[0]), .cpu_rdata(cpu_rdata), .php_wr(wr[1]),
    .php_rd(rd[1]), .php_addr(addr[1]), .php_wdata(wdata[1]), .php_rdata(php_rdata),
    .token_valid(token_valid), .token_addr(token_addr), .addr_match(addr_match),
    .xact_done(xact_done), .xact_ep(xact_ep), .xact_code(xact_code), .nak_irq_en(nak_en),
    .usb_reset_det(rst_det), .sof_eop_rx(sof_rx), .vbus_above_pin(vbus),
    .otg_id_pin(id_pin), .irq(irq));

  uda_usb_host_model host (.clk(clk), .reset(reset), .go(go), .eng(h_eng),
    .dev_addr(h_addr), .ep(h_ep), .code(h_code), .gap(h_gap), .token_valid(token_valid),
    .token_addr(token_addr), .xact_done(xact_done), .xact_ep(xact_ep),
    .xact_code(xact_code));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic reg_wr(input int p, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    wr[p] = 1'b1;
    addr[p] = a;
    wdata[p] = d;
    @(posedge clk);
    #1;
    wr[p] = 1'b0;
  endtask

  // read data lands at the edge that takes the strobe
  task automatic reg_rd(input int p, input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    #1;
    rd[p] = 1'b1;
    addr[p] = a;
    @(posedge clk);
    #1;
    rd[p] = 1'b0;
    chk(exp, p ? php_rdata : cpu_rdata);
  endtask

  task automatic xact(input logic e, input logic [6:0] a, input logic [2:0] ep,
                      input uda_xact_e c, input logic [1:0] g, input logic exp_hit);
    @(posedge clk);
    #1;
    go = 1'b1;
    h_eng = e;
    h_addr = a;
    h_ep = ep;
    h_code = c;
    h_gap = g;
    @(posedge clk);
    #1;
    go = 1'b0;
    chk({15'h0000, exp_hit}, {15'h0000, addr_match[e]});
    repeat (int'(g) + 3) @(posedge clk);
    #1;
  endtask

  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    reg_rd(0, OFS_IEN1, IEN_RESET);
    reg_rd(1, OFS_STAT2, STAT_RESET);
    reg_rd(0, OFS_ADDR1, 16'h0000);
    reg_rd(1, 16'hC092, 16'h0000);
    chk(16'h0000, {14'h0000, irq});
  endtask

  task automatic t_enables();
    reg_wr(0, OFS_IEN1, 16'hFFFF);
    reg_rd(0, OFS_IEN1, IEN_MASK1);
    reg_wr(1, OFS_IEN2, 16'hFFFF);
    reg_rd(1, OFS_IEN2, IEN_MASK2);
  endtask

  task automatic t_filter();
    xact(0, 7'h00, 3'h3, UDA_X_ACK_RX, 2'h0, 1'b1);
    reg_wr(0, OFS_ADDR1, 16'h0005);
    xact(0, 7'h00, 3'h4, UDA_X_ACK_TX, 2'h2, 1'b0);
    xact(0, 7'h05, 3'h2, UDA_X_ACK_TX, 2'h3, 1'b1);
    // engine two still answers only the default address
    xact(1, 7'h05, 3'h1, UDA_X_ACK_TX, 2'h0, 1'b0);
    reg_rd(1, OFS_STAT1, 16'h000C);
    reg_rd(0, OFS_STAT2, 16'h0000);
    reg_rd(0, OFS_ADDR1, 16'h0000);
    reg_wr(0, OFS_STAT1, 16'h000C);
  endtask

  task automatic t_codes();
    // reserved bits go out as zero; engine two keeps the default address
    reg_wr(1, OFS_ADDR2, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      xact(1, 7'h00, c[2:0], uda_xact_e'(c), 2'h0, 1'b1);
    end
    reg_rd(1, OFS_STAT2, 16'h003F);
    nak_en[1][6] = 1'b1;
    xact(1, 7'h00, 3'h6, UDA_X_NAK_TX, 2'h1, 1'b1);
    reg_rd(1, OFS_STAT2, 16'h007F);
  endtask

  task automatic t_clear_irq();
    chk(16'h0002, {14'h0000, irq});
    reg_wr(1, OFS_STAT2, 16'h0005);
    reg_wr(0, OFS_STAT2, 16'h0000);
    reg_rd(0, OFS_STAT2, 16'h007A);
    reg_wr(0, OFS_IEN2, 16'h0010);
    chk(16'h0002, {14'h0000, irq});
    reg_wr(1, OFS_STAT2, 16'h0010);
    chk(16'h0000, {14'h0000, irq});
  endtask

  task automatic t_bus_events();
    @(posedge clk);
    #1;
    rst_det[0] = 1'b1;
    @(posedge clk);
    #1;
    rst_det[0] = 1'b0;
    sof_rx[0] = 1'b1;
    @(posedge clk);
    #1;
    sof_rx[0] = 1'b0;
    chk(16'h0001, {14'h0000, irq});
    reg_rd(0, OFS_STAT1, 16'h0300);
    reg_wr(0, OFS_IEN1, 16'h0000);
    chk(16'h0000, {14'h0000, irq});
    reg_wr(0, OFS_STAT1, 16'h0300);
    reg_rd(1, OFS_STAT1, 16'h0000);
    // a clear and a new event in one cycle: the event must survive
    @(posedge clk);
    #1;
    wr[1] = 1'b1;
    addr[1] = OFS_STAT2;
    wdata[1] = 16'h0200;
    sof_rx[1] = 1'b1;
    @(posedge clk);
    #1;
    wr[1] = 1'b0;
    sof_rx[1] = 1'b0;
    reg_rd(1, OFS_STAT2, 16'h026A);
    reg_wr(1, OFS_STAT2, 16'h0200);
  endtask

  task automatic t_otg_pins();
    vbus = 1'b1;
    repeat (6) @(posedge clk);
    reg_rd(0, OFS_STAT1, 16'h8000);
    reg_wr(0, OFS_STAT1, 16'h8000);
    vbus = 1'b0;
    id_pin = 1'b1;
    repeat (6) @(posedge clk);
    reg_rd(0, OFS_STAT1, 16'hC000);
    reg_wr(0, OFS_STAT1, 16'h4000);
    id_pin = 1'b0;
    repeat (6) @(posedge clk);
    reg_rd(1, OFS_STAT1, 16'hC000);
    reg_rd(1, OFS_STAT2, 16'h006A);
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial begin
    {reset, go, h_eng, vbus, id_pin} = 5'h10;
    {wr, rd, rst_det, sof_rx, h_gap} = 10'h000;
    addr = '0;
    wdata = '0;
    nak_en = '0;
    h_addr = 7'h00;
    h_ep = 3'h0;
    h_code = UDA_X_NONE;
    miscompares = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset();
    t_enables();
    t_filter();
    t_codes();
    t_clear_irq();
    t_bus_events();
    t_otg_pins();
    summarize();
  end

  // whole run is under two hundred cycles
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule

`default_nettype wire
